// *** inc/timer16_pkg.sv ***
// constants, field positions and reset values of the 16-bit timer's
// capture, control and flag logic; assumes byte-wide registers on a
// simple strobe port clocked at the bus clock rate.
//
// Overview of operation
// - read-only 16-bit capture register latches the count on the chosen edge
// - reset never alters the capture register contents
// - captured value is at most one count past the pre-transition count via sync
// - capture resolution is one count; count steps every four bus clocks
// - every valid edge transfers the count, flag set or clear
// - reading capture high byte blocks transfers until the low byte is read
// - reading only the capture low byte never blocks transfers
// - capture always from port B bit 7; bit 6 shows level when enabled
// - control register read/write, six bits, three separate interrupt enables
// - run bit 1 runs the timer; 0 holds it in reset condition
// - edge select 1 rising, 0 falling; cleared by reset
// - level select loaded into output level on next compare match
// - capture flag set on edge; cleared by status then capture low access
// - match flag set on compare equal; cleared by status then compare low
// - wrap flag set on FFFF to 0000; cleared by status then count low
// - status access with wrap flag set arms its clearing
// - shadow count pair reads same count and never touches the wrap flag
// - timer keeps running in wait; enabled timer interrupt wakes the core
// - stop halts the count; reset exit forces the preset value
// - first edge in stop arms capture silently; flag and data show on wake
// - reset ending stop discards the pending capture flag and data
// - reset presets the count; counting starts once the run bit is set
// - high byte read latches low byte into buffer for the next low read
package timer16_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h12;
  localparam logic [7:0] ADDR_FLAGS = 8'h13;
  localparam logic [7:0] ADDR_CAP_HIGH = 8'h14;
  localparam logic [7:0] ADDR_CAP_LOW = 8'h15;
  localparam logic [7:0] ADDR_CMP_HIGH = 8'h16;
  localparam logic [7:0] ADDR_CMP_LOW = 8'h17;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h18;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h19;
  localparam logic [7:0] ADDR_SHADOW_HIGH = 8'h1A;
  localparam logic [7:0] ADDR_SHADOW_LOW = 8'h1B;

  // timer_control field positions
  localparam int CTL_CAPTURE_IE = 7;
  localparam int CTL_MATCH_IE = 6;
  localparam int CTL_WRAP_IE = 5;
  localparam int CTL_RUN = 4;
  localparam int CTL_EDGE_SELECT = 1;
  localparam int CTL_LEVEL_SELECT = 0;
  localparam logic [7:0] CONTROL_MASK = 8'hF3;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // timer_flags field positions
  localparam int FLG_CAPTURE = 7;
  localparam int FLG_MATCH = 6;
  localparam int FLG_WRAP = 5;

  // counter values
  localparam logic [15:0] COUNT_PRESET = 16'hFFFC;
  localparam logic [15:0] COUNT_WRAP = 16'hFFFF;
  localparam logic [15:0] COUNT_STEP = 16'h0001;

  // prescaler: one count every PRESCALE_DIV bus clocks
  localparam int PRESCALE_DIV = 4;
  localparam logic [1:0] PRESCALE_LAST = 2'(PRESCALE_DIV - 1);
  localparam logic [1:0] PRESCALE_RESET = 2'h0;

  localparam logic [7:0] READ_IDLE = 8'h00;

endpackage

// *** rtl/capture_edge_detect.sv ***
// synchroniser and edge detector for the capture input pin;
// assumes the pin is asynchronous to clk_in and slow against it.
module capture_edge_detect
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // pin and polarity
  input wire logic pin_in,
  input wire logic rising_in,
  // one-cycle pulse on the selected transition
  output logic edge_out
);

  typedef struct packed {
    logic stage1;
    logic stage2;
    logic prev;
  } sync_t;

  sync_t st;
  sync_t next_st;

  // two-flop synchroniser, then a history flop for edge detection
  always_comb
  begin
    next_st.stage1 = pin_in;
    next_st.stage2 = st.stage1;
    next_st.prev = st.stage2;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      st <= '0;
    else
      st <= next_st;
  end

  // only stage2 and prev are looked at; stage1 may be metastable
  assign edge_out = rising_in ? (st.stage2 & ~st.prev)
                              : (~st.stage2 & st.prev);

endmodule // capture_edge_detect

// *** rtl/timer16_capture_flags_ctrl.sv ***
// capture, control and flag logic of a 16-bit free-running timer,
// with the counter, its read buffer and the compare register.
// assumes a byte-wide strobe port at the bus clock and a capture pin
// that is synchronised here; stop and wait levels come from the core.
module timer16_capture_flags_ctrl
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // pins
  input wire logic port_b_bit7_in,
  input wire logic compare_pin_enable_in,
  output logic compare_out_pin_out,
  output logic port_b_bit6_out,
  output logic port_b_bit6_oe_out,
  // low-power modes
  input wire logic stop_mode_in,
  input wire logic wait_mode_in,
  // status to the rest of the chip
  output logic timer_irq_out,
  output logic match_event_out,
  output logic [15:0] count_out
);

  // all reset-cleared state
  typedef struct packed {
    logic [1:0] prescale;
    logic [15:0] count;
    logic [7:0] control;
    logic capture_flag;
    logic match_flag;
    logic wrap_flag;
    logic capture_arm;
    logic match_arm;
    logic wrap_arm;
    logic capture_hold;
    logic compare_hold;
    logic buf_full;
    logic [7:0] low_buf;
    logic stop_pending;
    logic [15:0] stop_value;
    logic in_stop;
    logic out_level;
    logic pin_oe;
    logic match_pulse;
    logic irq;
    logic [7:0] rdata;
  } state_t;

  // state that reset must not touch
  typedef struct packed {
    logic [15:0] capture;
    logic [15:0] compare;
  } data_t;

  state_t st;
  state_t next_st;
  data_t dat;
  data_t next_dat;

  logic edge_seen;

  // true when a strobe hits one address
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] target,
                               input logic strobe);
    hit = strobe && (addr == target);
  endfunction

  // capture pin is always port B bit 7
  capture_edge_detect edge_detect
  (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(port_b_bit7_in),
    .rising_in(st.control[timer16_pkg::CTL_EDGE_SELECT]),
    .edge_out(edge_seen)
  );

  // decoded accesses
  logic access;
  logic rd_cap_high;
  logic rd_cap_low;
  logic wr_cmp_high;
  logic wr_cmp_low;
  logic acc_cmp_low;
  logic acc_flags;
  logic acc_cap_low;
  logic acc_count_low;
  logic rd_count_high;
  logic rd_count_low;
  logic running;
  logic tick;
  logic [15:0] count_inc;
  logic wrap_event;
  logic match_event;
  logic capture_set;
  logic capture_load;
  logic [15:0] capture_src;
  logic wake;

  always_comb
  begin
    access = rd_in | wr_in;
    rd_cap_high = hit(addr_in, timer16_pkg::ADDR_CAP_HIGH, rd_in);
    rd_cap_low = hit(addr_in, timer16_pkg::ADDR_CAP_LOW, rd_in);
    acc_cap_low = hit(addr_in, timer16_pkg::ADDR_CAP_LOW, access);
    wr_cmp_high = hit(addr_in, timer16_pkg::ADDR_CMP_HIGH, wr_in);
    wr_cmp_low = hit(addr_in, timer16_pkg::ADDR_CMP_LOW, wr_in);
    acc_cmp_low = hit(addr_in, timer16_pkg::ADDR_CMP_LOW, access);
    acc_flags = hit(addr_in, timer16_pkg::ADDR_FLAGS, access);
    acc_count_low = hit(addr_in, timer16_pkg::ADDR_COUNT_LOW, access);
    // either pair's high byte fills the shared low-byte buffer
    rd_count_high = hit(addr_in, timer16_pkg::ADDR_COUNT_HIGH, rd_in)
                  | hit(addr_in, timer16_pkg::ADDR_SHADOW_HIGH, rd_in);
    rd_count_low = hit(addr_in, timer16_pkg::ADDR_COUNT_LOW, rd_in)
                 | hit(addr_in, timer16_pkg::ADDR_SHADOW_LOW, rd_in);
  end

  // counter timing and events
  always_comb
  begin
    running = st.control[timer16_pkg::CTL_RUN];
    // wait mode does not gate the count, stop mode does
    tick = running && !stop_mode_in
        && (st.prescale == timer16_pkg::PRESCALE_LAST);
    count_inc = 16'(st.count + timer16_pkg::COUNT_STEP);
    wrap_event = tick && (st.count == timer16_pkg::COUNT_WRAP);
    // the compare is held off between a high and a low byte write
    match_event = tick && !st.compare_hold
               && (count_inc == dat.compare);
    wake = st.in_stop && !stop_mode_in;
  end

  // capture source: live edge outside stop, parked edge on wake-up
  always_comb
  begin
    capture_set = 1'b0;
    capture_src = st.count;
    if (wake && st.stop_pending)
    begin
      capture_set = 1'b1;
      capture_src = st.stop_value;
    end
    else if (edge_seen && running && !stop_mode_in)
    begin
      // the count has already moved on during synchronisation
      capture_set = 1'b1;
      capture_src = st.count;
    end
    // flag state is irrelevant; only a pending high-byte read blocks
    capture_load = capture_set && !st.capture_hold;
  end

  always_comb
  begin
    next_st = st;
    next_dat = dat;
    next_st.rdata = timer16_pkg::READ_IDLE;
    next_st.in_stop = stop_mode_in;
    next_st.pin_oe = compare_pin_enable_in;
    next_st.match_pulse = match_event;

    // prescaler and counter; run bit low holds the reset condition
    if (!running)
    begin
      next_st.prescale = timer16_pkg::PRESCALE_RESET;
      next_st.count = timer16_pkg::COUNT_PRESET;
    end
    else if (!stop_mode_in)
    begin
      next_st.prescale = 2'(st.prescale + 2'h1);
      if (tick)
        next_st.count = count_inc;
    end

    // first edge seen in stop is parked, later ones are dropped
    if (stop_mode_in && running && edge_seen && !st.stop_pending)
    begin
      next_st.stop_pending = 1'b1;
      next_st.stop_value = st.count;
    end
    if (wake)
      next_st.stop_pending = 1'b0;

    if (capture_load)
      next_dat.capture = capture_src;

    // compare register writes; a lone low byte write does not inhibit
    if (wr_cmp_high)
    begin
      next_dat.compare[15:8] = wdata_in;
      next_st.compare_hold = 1'b1;
    end
    if (wr_cmp_low)
    begin
      next_dat.compare[7:0] = wdata_in;
      next_st.compare_hold = 1'b0;
    end

    // level select goes to the pin only on a match
    if (match_event)
      next_st.out_level = st.control[timer16_pkg::CTL_LEVEL_SELECT];

    // control register: six implemented bits
    if (hit(addr_in, timer16_pkg::ADDR_CONTROL, wr_in))
      next_st.control = wdata_in & timer16_pkg::CONTROL_MASK;

    // second step of the flag clears: the register behind each flag
    if (st.capture_arm && acc_cap_low)
    begin
      next_st.capture_flag = 1'b0;
      next_st.capture_arm = 1'b0;
    end
    if (st.match_arm && acc_cmp_low)
    begin
      next_st.match_flag = 1'b0;
      next_st.match_arm = 1'b0;
    end
    // only the main pair clears the wrap flag, never the shadow pair
    if (st.wrap_arm && acc_count_low)
    begin
      next_st.wrap_flag = 1'b0;
      next_st.wrap_arm = 1'b0;
    end

    // first step: any status access arms each flag that is set
    if (acc_flags)
    begin
      next_st.capture_arm = st.capture_flag;
      next_st.match_arm = st.match_flag;
      // a stray status read then count read will clear the wrap flag
      next_st.wrap_arm = st.wrap_flag;
    end

    // set wins over a clear in the same cycle
    if (capture_set)
      next_st.capture_flag = 1'b1;
    if (match_event)
      next_st.match_flag = 1'b1;
    if (wrap_event)
      next_st.wrap_flag = 1'b1;

    // capture byte reads: the high byte freezes transfers
    if (rd_cap_high)
    begin
      next_st.rdata = dat.capture[15:8];
      next_st.capture_hold = 1'b1;
    end
    if (rd_cap_low)
    begin
      // a low read alone leaves the transfer path open
      next_st.rdata = dat.capture[7:0];
      next_st.capture_hold = 1'b0;
    end

    // counter reads through the shared low-byte buffer
    if (rd_count_high)
    begin
      next_st.rdata = st.count[15:8];
      // repeated high reads keep the first buffered low byte
      if (!st.buf_full)
      begin
        next_st.low_buf = st.count[7:0];
        next_st.buf_full = 1'b1;
      end
    end
    if (rd_count_low)
    begin
      next_st.rdata = st.buf_full ? st.low_buf : st.count[7:0];
      next_st.buf_full = 1'b0;
    end

    // remaining readable registers
    if (hit(addr_in, timer16_pkg::ADDR_CONTROL, rd_in))
      next_st.rdata = st.control;
    else if (hit(addr_in, timer16_pkg::ADDR_FLAGS, rd_in))
    begin
      next_st.rdata = timer16_pkg::READ_IDLE;
      next_st.rdata[timer16_pkg::FLG_CAPTURE] = st.capture_flag;
      next_st.rdata[timer16_pkg::FLG_MATCH] = st.match_flag;
      next_st.rdata[timer16_pkg::FLG_WRAP] = st.wrap_flag;
    end
    else if (hit(addr_in, timer16_pkg::ADDR_CMP_HIGH, rd_in))
      next_st.rdata = dat.compare[15:8];
    else if (hit(addr_in, timer16_pkg::ADDR_CMP_LOW, rd_in))
      next_st.rdata = dat.compare[7:0];

    // one request line; in wait mode it also wakes the core
    next_st.irq =
      (next_st.capture_flag
        & next_st.control[timer16_pkg::CTL_CAPTURE_IE])
      | (next_st.match_flag
        & next_st.control[timer16_pkg::CTL_MATCH_IE])
      | (next_st.wrap_flag
        & next_st.control[timer16_pkg::CTL_WRAP_IE]);
  end

  // reset-cleared state; the wait level needs no state of its own
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st <= '0;
      // a reset ending stop also drops any parked capture
      st.stop_pending <= 1'b0;
      st.count <= timer16_pkg::COUNT_PRESET;
      st.control <= timer16_pkg::CONTROL_RESET;
    end
    else
      st <= next_st;
  end

  // capture and compare bytes survive reset on purpose
  always_ff @(posedge clk_in)
  begin
    dat <= next_dat;
  end

  // outputs, all straight from flops
  assign rdata_out = st.rdata;
  assign compare_out_pin_out = st.out_level;
  assign port_b_bit6_out = st.out_level;
  assign port_b_bit6_oe_out = st.pin_oe;
  assign timer_irq_out = st.irq;
  assign match_event_out = st.match_pulse;
  assign count_out = st.count;

  // wait mode is accepted only to document that it changes nothing
  logic unused_wait;
  assign unused_wait = wait_mode_in;

endmodule // timer16_capture_flags_ctrl

// *** verification/timer16_chk.sv ***
// port assertions for the timer capture, control and flag block
// bound into every instance; sees only the block's ports
module timer16_chk
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // pins and mode levels
  input wire logic compare_pin_enable_in,
  input wire logic compare_out_pin_out,
  input wire logic port_b_bit6_out,
  input wire logic port_b_bit6_oe_out,
  input wire logic stop_mode_in,
  input wire logic wait_mode_in,
  // counter status
  input wire logic match_event_out,
  input wire logic [15:0] count_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // a count step that is not the return to the preset
  sequence tick_s;
    $changed(count_out) && count_out != timer16_pkg::COUNT_PRESET;
  endsequence
  // three edges with no step; stopping the timer may preset it
  sequence rest_s;
    ($stable(count_out) || count_out == timer16_pkg::COUNT_PRESET)[*3];
  endsequence

  a_count_step: assert property (
    tick_s |-> count_out == $past(count_out) + 16'h0001)
    else $error("count moved by other than one");
  a_count_gap: assert property (
    tick_s |=> rest_s)
    else $error("count stepped sooner than four clocks");
  a_match_pulse: assert property (
    match_event_out |=> !match_event_out [*3])
    else $error("match pulse too long or too close");
  a_pin_on_match: assert property (
    $changed(compare_out_pin_out) |-> ##[0:1] match_event_out)
    else $error("compare pin changed without a match");
  a_pin_mirror: assert property (
    port_b_bit6_out == compare_out_pin_out)
    else $error("bit6 differs from the compare level");
  a_oe_follow: assert property (
    $past(rst_n_in) |-> port_b_bit6_oe_out == $past(compare_pin_enable_in))
    else $error("bit6 enable does not follow its control");
  a_stop_frozen: assert property (
    stop_mode_in && $past(stop_mode_in) |-> $stable(count_out))
    else $error("count moved in stop");
  a_wait_runs: assert property (
    wait_mode_in ##0 tick_s |-> ##4 $changed(count_out))
    else $error("count halted in wait");
endmodule // timer16_chk

bind timer16_capture_flags_ctrl timer16_chk chk_u (.*);

// *** verification/capture_source.sv ***
// far-side pulse source on the capture pin
// assumes the bench holds each level for several clocks
module capture_source
(
  // level asked for by the bench
  input wire logic level_in,
  // pin towards the timer
  output logic pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin_out = 1'b0;
  // a fixed skew keeps pin changes away from the clock edges
  always @(level_in) pin_out <= #37 level_in;
endmodule // capture_source

// *** verification/test_timer16_capture_flags_ctrl.sv ***
// self-checking bench for the timer capture, control and flag block
// assumes the bound checker and the capture pulse source model
module test_timer16_capture_flags_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  // design inputs, all valued at time zero
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic port_b_bit7_in;
  logic compare_pin_enable_in = 1'b0;
  logic stop_mode_in = 1'b0;
  logic wait_mode_in = 1'b0;
  logic cap_level = 1'b0;
  // design outputs
  logic [7:0] rdata_out;
  logic compare_out_pin_out;
  logic port_b_bit6_out;
  logic port_b_bit6_oe_out;
  logic timer_irq_out;
  logic match_event_out;
  logic [15:0] count_out;
  // bookkeeping; edge indices come from cyc
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int e0 = 0;
  int we = 0;
  int re = 0;
  int pe = 0;
  int p1 = 0;
  logic [7:0] hi;
  logic [7:0] lo;
  logic [15:0] x;

  timer16_capture_flags_ctrl dut_u (.*);
  capture_source src_u (.level_in(cap_level), .pin_out(port_b_bit7_in));

  // 100 ns bus clock
  always #50 clk_in = ~clk_in;

  // edge counter; also cuts a hung run short
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  // count seen at edge e; steps land every fourth edge after run is set
  function automatic logic [15:0] cnt(input int e);
    return 16'(32'hFFFC + (e - e0 - 1) / 4);
  endfunction

  task automatic chk(input string n, input logic [15:0] s,
                     input logic [15:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // bus cycles: strobes rise after one edge and are sampled at the next
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1 we = cyc;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
    re = cyc;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a, hi);
    chk($sformatf("reg %h", a), 16'(hi), 16'(e));
  endtask

  // high byte then low byte a while later must give the count at the high
  task automatic pair(input logic [7:0] a);
    rd(a, hi);
    x = cnt(re);
    repeat (6) @(posedge clk_in);
    rd(a + 8'h01, lo);
    chk("count pair", {hi, lo}, x);
  endtask

  task automatic pin(input logic v);
    @(posedge clk_in);
    cap_level <= v;
    #1 pe = cyc;
    repeat (8) @(posedge clk_in);
  endtask

  // synchronising delay allows the capture up to two counts late
  task automatic grab(input int p);
    rc(8'h13, 8'h80);
    rd(8'h14, hi);
    rd(8'h15, lo);
    chk("capture", 16'({hi, lo} - cnt(p) <= 16'h0002), 16'h0001);
    rc(8'h13, 8'h00);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    // reset state and register access kinds
    rc(8'h12, 8'h00);
    rc(8'h13, 8'h00);
    wr(8'h18, 8'h00);
    rc(8'h18, 8'hFF);
    rc(8'h19, 8'hFC);
    wr(8'h12, 8'hEF);
    rc(8'h12, 8'hE3);
    rc(8'h19, 8'hFC);
    rc(8'h30, 8'h00);
    wr(8'h16, 8'h80);
    wr(8'h17, 8'h00);
    $display("test reset done");
    // wrap flag, its clearing and the shadow pair
    wr(8'h12, 8'h10);
    e0 = we;
    repeat (24) @(posedge clk_in);
    rc(8'h13, 8'h20);
    chk("irq masked", 16'(timer_irq_out), 16'h0000);
    wr(8'h12, 8'h30);
    rc(8'h13, 8'h20);
    chk("irq wrap", 16'(timer_irq_out), 16'h0001);
    pair(8'h1A);
    rc(8'h13, 8'h20);
    pair(8'h18);
    rc(8'h13, 8'h00);
    $display("test wrap done");
    // capture on both polarities, with the high-byte hold
    wr(8'h12, 8'hB2);
    pin(1'b1);
    chk("irq capture", 16'(timer_irq_out), 16'h0001);
    grab(pe);
    p1 = pe;
    rd(8'h14, hi);
    pin(1'b0);
    pin(1'b1);
    rd(8'h15, lo);
    chk("held", 16'({hi, lo} - cnt(p1) <= 16'h0002), 16'h0001);
    rd(8'h15, lo);
    pin(1'b0);
    pin(1'b1);
    grab(pe);
    wr(8'h12, 8'h90);
    pin(1'b0);
    grab(pe);
    $display("test capture done");
    // compare match drives each level onto the shared pin
    @(posedge clk_in);
    compare_pin_enable_in <= 1'b1;
    for (int v = 1; v >= 0; v--)
    begin
      wr(8'h12, 8'h50 | 8'(v));
      x = cnt(we) + 16'h0008;
      wr(8'h16, x[15:8]);
      wr(8'h17, x[7:0]);
      repeat (40) @(posedge clk_in);
      chk("level", 16'(compare_out_pin_out), 16'(v));
      chk("bit6", 16'({port_b_bit6_oe_out, port_b_bit6_out}), 16'(2 + v));
      chk("irq match", 16'(timer_irq_out), 16'h0001);
      rc(8'h13, 8'h40);
      rc(8'h17, x[7:0]);
      rc(8'h13, 8'h00);
    end
    $display("test compare done");
    // stop parks the first capture; reset ending stop drops it
    wr(8'h12, 8'h12);
    @(posedge clk_in);
    stop_mode_in <= 1'b1;
    pin(1'b1);
    rc(8'h13, 8'h00);
    @(posedge clk_in);
    stop_mode_in <= 1'b0;
    rc(8'h13, 8'h80);
    rd(8'h15, lo);
    @(posedge clk_in);
    stop_mode_in <= 1'b1;
    pin(1'b0);
    pin(1'b1);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    stop_mode_in <= 1'b0;
    rc(8'h13, 8'h00);
    rc(8'h18, 8'hFF);
    rc(8'h19, 8'hFC);
    // the timer keeps counting in wait
    wr(8'h12, 8'h10);
    e0 = we;
    @(posedge clk_in);
    wait_mode_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    pair(8'h18);
    $display("test low power done");
    tally_and_finish();
  end
endmodule // test_timer16_capture_flags_ctrl
